// *** core/lfe_top.sv ***
// programmable output and marker logic of a cam controller
// assumes cam tracks come from logic on clk_sys_in, field inputs are asynchronous
//
// Functional notes
// - a program can make output one cam track one and input seven and not input sixteen, or input three.
// - a change on a contributing input reaches the output well within 1.5 ms.
// - each selected trigger edge of an output restarts its switch-off delay.
// - while the switch-off delay runs the output stays active whatever the logic says.
// - a count cam for any revolution 1 to 32 is built only from expressions and the shift register.
// - the fifth-revolution count cam uses track one as shift clock and data and shift bit five as reset.
// - each expression is evaluated strictly left to right.
// - each expression has at most three operations on at most four operands.
// - the shift register clears on marker sixteen, shifts in marker fifteen on marker fourteen rising.
// - the switch-off delay is 0 to 255 ms with a chosen edge, on outputs one to eight only.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "lfe_regs.svh"

module lfe_top #(
   parameter int CYCLE_CLKS = `LFE_CYCLE_CLKS,
   parameter int MS_CLKS = `LFE_MS_CLKS
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // cam tracks and field inputs
   input wire logic [15:0] cam_track_in,
   input wire logic [15:0] input_pin_in,
   // register port
   input wire logic [`LFE_ADDR_W-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // switching outputs
   output logic [15:0] output_pin_out
);
   // ==================================================
   // declarations
   logic [16:0] cycle_cnt, next_cycle_cnt;
   logic [16:0] ms_cnt, next_ms_cnt;
   logic cycle_tick, ms_tick;
   logic [15:0] in_meta, in_sync;
   logic [27:0] opnd_cfg [`LFE_N_EXPR];
   logic [27:0] next_opnd_cfg [`LFE_N_EXPR];
   logic [8:0] ops_cfg [`LFE_N_EXPR];
   logic [8:0] next_ops_cfg [`LFE_N_EXPR];
   logic [8:0] switch_off_delay_cfg [`LFE_N_SWITCH_OFF_DELAY];
   logic [8:0] next_switch_off_delay_cfg [`LFE_N_SWITCH_OFF_DELAY];
   logic [`LFE_N_OPND-1:0] opnd_vec;
   logic [`LFE_N_EXPR-1:0] expr_res;
   logic [15:0] logic_res, next_logic_res;
   logic [15:0] marker, next_marker;
   logic [31:0] shift_reg, next_shift_reg;
   logic clk_mark_prev, next_clk_mark_prev;
   logic [7:0] switch_off_delay_cnt [`LFE_N_SWITCH_OFF_DELAY];
   logic [7:0] next_switch_off_delay_cnt [`LFE_N_SWITCH_OFF_DELAY];
   logic [15:0] next_output;
   logic [31:0] next_rdata;
   logic [6:0] word_idx;

   // ==================================================
   // dividers: processing cycle and millisecond enables
   assign cycle_tick = (cycle_cnt == 17'(CYCLE_CLKS - 1));
   assign ms_tick = (ms_cnt == 17'(MS_CLKS - 1));

   always_comb begin
      next_cycle_cnt = cycle_tick ? 17'h00000 : cycle_cnt + 17'h00001;
      next_ms_cnt = ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cycle_cnt <= 17'h00000;
         ms_cnt <= 17'h00000;
      end else begin
         cycle_cnt <= next_cycle_cnt;
         ms_cnt <= next_ms_cnt;
      end
   end

   // ==================================================
   // field input synchroniser, second stage is the only reader of the first
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         in_meta <= 16'h0000;
         in_sync <= 16'h0000;
      end else begin
         in_meta <= input_pin_in;
         in_sync <= in_meta;
      end
   end

   // ==================================================
   // program words, written over the register port
   assign word_idx = reg_addr_in[8:2];

   always_comb begin
      for (int i = 0; i < `LFE_N_EXPR; i++) begin
         next_opnd_cfg[i] = opnd_cfg[i];
         next_ops_cfg[i] = ops_cfg[i];
      end
      for (int k = 0; k < `LFE_N_SWITCH_OFF_DELAY; k++) begin
         next_switch_off_delay_cfg[k] = switch_off_delay_cfg[k];
      end
      if (reg_wr_in && reg_addr_in[1:0] == 2'h0) begin
         if (reg_addr_in[8:7] == 2'h0) begin
            next_opnd_cfg[word_idx[4:0]] = reg_wdata_in[27:0];
         end else if (reg_addr_in[8:7] == 2'h1) begin
            next_ops_cfg[word_idx[4:0]] = reg_wdata_in[8:0];
         end else if (reg_addr_in[8:5] == 4'h8) begin
            next_switch_off_delay_cfg[word_idx[2:0]] = reg_wdata_in[8:0];
         end
      end
   end

   // delivered state: every output and marker follows its own cam track
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < `LFE_N_EXPR; i++) begin
            opnd_cfg[i] <= 28'(`LFE_OPND_CAM + (i % 16));
            ops_cfg[i] <= `LFE_OPS_RESET;
         end
         for (int k = 0; k < `LFE_N_SWITCH_OFF_DELAY; k++) begin
            switch_off_delay_cfg[k] <= `LFE_SWITCH_OFF_DELAY_RESET;
         end
      end else begin
         for (int i = 0; i < `LFE_N_EXPR; i++) begin
            opnd_cfg[i] <= next_opnd_cfg[i];
            ops_cfg[i] <= next_ops_cfg[i];
         end
         for (int k = 0; k < `LFE_N_SWITCH_OFF_DELAY; k++) begin
            switch_off_delay_cfg[k] <= next_switch_off_delay_cfg[k];
         end
      end
   end

   // ==================================================
   // expression bank: sixteen outputs then sixteen markers
   assign opnd_vec = {shift_reg, marker, cam_track_in, in_sync};

   for (genvar g = 0; g < `LFE_N_EXPR; g++) begin : g_expr
      lfe_expr u_expr (
         .operands_in(opnd_vec),
         .sel_in(opnd_cfg[g]),
         .ops_in(ops_cfg[g]),
         .result_out(expr_res[g])
      );
   end

   // ==================================================
   // cycle evaluation, markers and shift register
   // markers feed back with last cycle's value, so count cams need no loop
   always_comb begin
      next_logic_res = logic_res;
      next_marker = marker;
      next_shift_reg = shift_reg;
      next_clk_mark_prev = clk_mark_prev;
      if (cycle_tick) begin
         next_logic_res = expr_res[15:0];
         next_marker = expr_res[31:16];
         next_clk_mark_prev = marker[13];
         if (marker[15]) begin
            next_shift_reg = 32'h00000000;
         end else if (marker[13] && !clk_mark_prev) begin
            next_shift_reg = {shift_reg[30:0], marker[14]};
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         logic_res <= 16'h0000;
         marker <= 16'h0000;
         shift_reg <= 32'h00000000;
         clk_mark_prev <= 1'b0;
      end else begin
         logic_res <= next_logic_res;
         marker <= next_marker;
         shift_reg <= next_shift_reg;
         clk_mark_prev <= next_clk_mark_prev;
      end
   end

   // ==================================================
   // switch-off delay timers, a retrigger in a ms tick beats the count-down
   // granularity is the free ms tick, so a delay of n lasts n-1 to n ms
   always_comb begin
      logic trig;
      trig = 1'b0;
      for (int k = 0; k < `LFE_N_SWITCH_OFF_DELAY; k++) begin
         next_switch_off_delay_cnt[k] = switch_off_delay_cnt[k];
         if (switch_off_delay_cfg[k][`LFE_SWITCH_OFF_DELAY_EDGE_BIT]) begin
            trig = logic_res[k] && !next_logic_res[k];
         end else begin
            trig = !logic_res[k] && next_logic_res[k];
         end
         if (cycle_tick && trig) begin
            next_switch_off_delay_cnt[k] = switch_off_delay_cfg[k][7:0];
         end else if (ms_tick && switch_off_delay_cnt[k] != 8'h00) begin
            next_switch_off_delay_cnt[k] = switch_off_delay_cnt[k] - 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         for (int k = 0; k < `LFE_N_SWITCH_OFF_DELAY; k++) begin
            switch_off_delay_cnt[k] <= 8'h00;
         end
      end else begin
         for (int k = 0; k < `LFE_N_SWITCH_OFF_DELAY; k++) begin
            switch_off_delay_cnt[k] <= next_switch_off_delay_cnt[k];
         end
      end
   end

   // ==================================================
   // pin drivers, running delay overrides the logic result
   always_comb begin
      next_output = logic_res;
      for (int k = 0; k < `LFE_N_SWITCH_OFF_DELAY; k++) begin
         next_output[k] = logic_res[k] | (switch_off_delay_cnt[k] != 8'h00);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         output_pin_out <= 16'h0000;
      end else begin
         output_pin_out <= next_output;
      end
   end

   // ==================================================
   // register read-back, data stand one cycle only, unmapped reads zero
   always_comb begin
      next_rdata = 32'h00000000;
      if (reg_rd_in && reg_addr_in[1:0] == 2'h0) begin
         if (reg_addr_in[8:7] == 2'h0) begin
            next_rdata = {4'h0, opnd_cfg[word_idx[4:0]]};
         end else if (reg_addr_in[8:7] == 2'h1) begin
            next_rdata = {23'h000000, ops_cfg[word_idx[4:0]]};
         end else if (reg_addr_in[8:5] == 4'h8) begin
            next_rdata = {23'h000000, switch_off_delay_cfg[word_idx[2:0]]};
         end else if (reg_addr_in == `LFE_OFS_OUT) begin
            next_rdata = {16'h0000, output_pin_out};
         end else if (reg_addr_in == `LFE_OFS_MARK) begin
            next_rdata = {16'h0000, marker};
         end else if (reg_addr_in == `LFE_OFS_SHIFT) begin
            next_rdata = shift_reg;
         end else if (reg_addr_in == `LFE_OFS_INPUT) begin
            next_rdata = {16'h0000, in_sync};
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 32'h00000000;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end
endmodule

// *** core/lfe_regs.svh ***
// constants of the cam output logic block: offsets, fields, resets, timing
// assumes a 100 MHz system clock and a plain word-wide register port
`ifndef LFE_REGS_SVH
`define LFE_REGS_SVH

// ==================================================
// timing
`define LFE_CLK_NS 10
`define LFE_CYCLE_NS 100000
`define LFE_CYCLE_CLKS (`LFE_CYCLE_NS / `LFE_CLK_NS)
`define LFE_MS_NS 1000000
`define LFE_MS_CLKS (`LFE_MS_NS / `LFE_CLK_NS)
`define LFE_LATENCY_MAX_NS 1500000

// ==================================================
// sizes
`define LFE_N_OUT 16
`define LFE_N_MRK 16
`define LFE_N_EXPR 32
`define LFE_N_SWITCH_OFF_DELAY 8
`define LFE_N_OPND 80
`define LFE_SEL_W 7
`define LFE_ADDR_W 9

// ==================================================
// operand index bases
`define LFE_OPND_INPUT 0
`define LFE_OPND_CAM 16
`define LFE_OPND_MARK 32
`define LFE_OPND_SHIFT 48

// ==================================================
// register byte offsets
`define LFE_OFS_OPND 9'h000
`define LFE_OFS_OPS 9'h080
`define LFE_OFS_SWITCH_OFF_DELAY 9'h100
`define LFE_OFS_OUT 9'h120
`define LFE_OFS_MARK 9'h124
`define LFE_OFS_SHIFT 9'h128
`define LFE_OFS_INPUT 9'h12c

// ==================================================
// fields of the operation word and the delay word
`define LFE_OPS_NOPS_LSB 6
`define LFE_OPS_INV_BIT 8
`define LFE_SWITCH_OFF_DELAY_EDGE_BIT 8
`define LFE_OPS_RESET 9'h000
`define LFE_SWITCH_OFF_DELAY_RESET 9'h000

`endif

// *** core/lfe_pkg.sv ***
// types of the cam output logic block
// assumes lfe_regs.svh supplies all numbers
package lfe_pkg;
   // ==================================================
   // logic operations of a chain link
   typedef enum logic [1:0] {
      LFE_AND = 2'h0,
      LFE_OR = 2'h1,
      LFE_AND_NOT = 2'h2,
      LFE_OR_NOT = 2'h3
   } lfe_op_e;
endpackage

// *** core/lfe_expr.sv ***
// one logic expression: up to four operands, three chained operations
// assumes operands and program words are stable registers of one clock
`timescale 1ns/10ps
`include "lfe_regs.svh"

module lfe_expr (
   // operand pool and program
   input wire logic [`LFE_N_OPND-1:0] operands_in,
   input wire logic [4*`LFE_SEL_W-1:0] sel_in,
   input wire logic [8:0] ops_in,
   // result
   output logic result_out
);
   // ==================================================
   // operand pick, out-of-range selects read as zero
   function automatic logic pick(input logic [`LFE_SEL_W-1:0] s,
                                 input logic [`LFE_N_OPND-1:0] v);
      logic r;
      r = 1'b0;
      if (s < 7'(`LFE_N_OPND)) begin
         r = v[s];
      end
      return r;
   endfunction

   // ==================================================
   // left to right, no precedence between operations
   always_comb begin
      logic acc;
      logic b;
      logic [1:0] nops;
      acc = pick(sel_in[`LFE_SEL_W-1:0], operands_in);
      b = 1'b0;
      nops = ops_in[`LFE_OPS_NOPS_LSB +: 2];
      for (int j = 1; j < 4; j++) begin
         if (2'(j) <= nops) begin
            b = pick(sel_in[`LFE_SEL_W*j +: `LFE_SEL_W], operands_in);
            unique case (lfe_pkg::lfe_op_e'(ops_in[2*(j-1) +: 2]))
               lfe_pkg::LFE_AND: acc = acc & b;
               lfe_pkg::LFE_OR: acc = acc | b;
               lfe_pkg::LFE_AND_NOT: acc = acc & ~b;
               lfe_pkg::LFE_OR_NOT: acc = acc | ~b;
            endcase
         end
      end
      result_out = acc ^ ops_in[`LFE_OPS_INV_BIT]; // inverted output or marker
   end
endmodule

// *** tb/lfe_field_model.sv ***
// field side model: the 24V inputs seen by the block
// assumes one clock; a new level waits until the old one stood long enough
`timescale 1ns/10ps

module lfe_field_model #(
   parameter int HOLD_CLKS = 8
) (
   // clock
   input wire logic clk_sys_in,
   // requested and driven levels
   input wire logic [15:0] want_in,
   output logic [15:0] input_pin_out
);
   int held = 0;
   initial input_pin_out = 16'h0;
   // =====
   // short pulses would be missed by the sampling, so each level is held
   always @(posedge clk_sys_in) begin
      held <= held + 1;
      if (want_in !== input_pin_out && held >= HOLD_CLKS) begin
         input_pin_out <= want_in;
         held <= 0;
      end
   end
endmodule

// *** tb/lfe_top_assertions.sv ***
// checker of the cam output logic top: read port and output timing
// assumes a processing cycle of 8 clocks, one clock, synchronous reset
`timescale 1ns/10ps
`include "lfe_regs.svh"

module lfe_checker #(
   parameter int CYCLE_CLKS = 8,
   parameter int MS_CLKS = 16
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // field side
   input wire logic [15:0] cam_track_in,
   input wire logic [15:0] input_pin_in,
   input wire logic [15:0] output_pin_out,
   // register port
   input wire logic [`LFE_ADDR_W-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out
);
   // =====
   // one clock domain, so clock and reset are shared
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data outside read answer");
   a_bad_read: assert property (reg_rd_in && (reg_addr_in[1:0] != 2'h0 || reg_addr_in > 9'h12c)
      |=> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
   a_out_read: assert property ((reg_rd_in && reg_addr_in == 9'h120 && $stable(output_pin_out))
      ##1 $stable(output_pin_out) |-> reg_rdata_out == {16'h0, output_pin_out})
      else $error("output word differs from pins");
   a_in_read: assert property ($stable(input_pin_in)[*4] ##0 (reg_rd_in && reg_addr_in == 9'h12c)
      |=> reg_rdata_out == {16'h0, $past(input_pin_in)}) else $error("input word wrong");
   a_wr_quiet: assert property (reg_wr_in |=> reg_rdata_out == 32'h0)
      else $error("write gave read data");
   a_mark_upper: assert property (reg_rd_in && reg_addr_in == 9'h124
      |=> reg_rdata_out[31:16] == 16'h0) else $error("marker word upper bits set");
   a_out_hold: assert property ($changed(output_pin_out[15:8])
      |=> $stable(output_pin_out[15:8])[*7]) else $error("outputs changed inside a cycle");
   a_reset_quiet: assert property ($rose(rst_n_in)
      |-> output_pin_out == 16'h0 && reg_rdata_out == 32'h0) else $error("not quiet at reset");
endmodule

bind lfe_top lfe_checker #(.CYCLE_CLKS(CYCLE_CLKS), .MS_CLKS(MS_CLKS)) u_chk (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cam_track_in(cam_track_in),
   .input_pin_in(input_pin_in), .output_pin_out(output_pin_out), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out));

// *** tb/cam_output_logic_function_tb.sv ***
// self-checking bench of the cam output logic top
// assumes shortened cycle (8 clocks) and ms (16 clocks); reads answered one cycle later
`timescale 1ns/10ps
`include "lfe_regs.svh"
`define LFE_CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module cam_output_logic_function_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] cam = 16'h0;
   logic [15:0] want = 16'h0;
   logic [15:0] pins;
   logic [8:0] addr = 9'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [15:0] outp;
   logic p1 = 1'b0;
   logic [8:0] pa = 9'h0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] e_w;
   logic [31:0] m_w;
   logic [8:0] ops;
   logic [3:0] v;
   int fails = 0;
   int checks = 0;

   lfe_top #(.CYCLE_CLKS(8), .MS_CLKS(16)) dut (.clk_sys_in(clk), .rst_n_in(rst_n),
      .cam_track_in(cam), .input_pin_in(pins), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .output_pin_out(outp));
   lfe_field_model #(.HOLD_CLKS(8)) field (.clk_sys_in(clk), .want_in(want),
      .input_pin_out(pins));

   // =====
   // clock, and the left-to-right reference of one expression
   initial forever #5 clk = ~clk;
   function automatic logic lr(input logic [3:0] x, input logic [8:0] o);
      logic r;
      r = x[0];
      for (int k = 0; k < 3; k++) begin
         case (o[2*k +: 2])
            2'h0: r = r & x[k+1];
            2'h1: r = r | x[k+1];
            2'h2: r = r & ~x[k+1];
            default: r = r | ~x[k+1];
         endcase
      end
      return r ^ o[8];
   endfunction

   // =====
   // bus tasks; a read leaves its expectation in the queue
   task automatic clks(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // read data stand only in the cycle after the read edge, so compare mid-cycle there
   // an output word read is also held against the pins themselves
   always @(posedge clk) begin
      p1 <= rd;
      pa <= addr;
   end
   always @(negedge clk) begin
      if (p1) begin
         e_w = exp_q.pop_front();
         m_w = msk_q.pop_front();
         `LFE_CHK("read word", e_w, rdata & m_w)
         if (pa == 9'h120) begin
            `LFE_CHK("output pins", e_w, {16'h0, outp} & m_w)
         end
      end
   end

   // watchdog, far beyond the few thousand clocks needed
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict();
   end

   // =====
   // delivered program, read-only and unmapped words
   initial begin
      void'($urandom(22477));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      cam <= 16'($urandom);
      clks(24);
      rd_chk(9'h120, {16'h0, cam}, 32'hffff);
      rd_chk(9'h124, {16'h0, cam}, 32'hffff);
      wr_reg(9'h120, 32'h0);
      rd_chk(9'h120, {16'h0, cam}, 32'hffff);
      rd_chk(9'h130, 32'h0, 32'hffffffff);
      rd_chk(9'h122, 32'h0, 32'hffffffff);
      // random chains on inputs one to four, then the three-input example
      for (int i = 0; i < 20; i++) begin
         ops = (i < 12) ? {1'($urandom), 2'h3, 4'($urandom), 2'(i)} : 9'h0d8;
         wr_reg(9'h000, (i < 12) ? 32'h00608080 : 32'h0043c310);
         wr_reg(9'h080, {23'h0, ops});
         want <= 16'($urandom);
         cam <= 16'($urandom);
         clks(24);
         v = (i < 12) ? want[3:0] : {want[2], want[15], want[6], cam[0]};
         rd_chk(9'h120, {31'h0, lr(v, ops)}, 32'h1);
      end
      rd_chk(9'h12c, {16'h0, want}, 32'hffff);
      // count cam: empty the shift register, then ten revolutions
      wr_reg(9'h074, 32'h10);
      wr_reg(9'h078, 32'h10);
      wr_reg(9'h07c, 32'h10);
      cam[0] <= 1'b1;
      clks(24);
      cam[0] <= 1'b0;
      clks(24);
      wr_reg(9'h07c, 32'h34);
      wr_reg(9'h000, 32'h1010);
      wr_reg(9'h080, 32'h40);
      wr_reg(9'h040, 32'hbd010);
      wr_reg(9'h0c0, 32'h84);
      for (int r = 1; r <= 10; r++) begin
         cam[0] <= 1'b1;
         clks(56);
         rd_chk(9'h120, {31'h0, r % 5 == 0}, 32'h1);
         cam[0] <= 1'b0;
         clks(64);
      end
      // 10 ms leading-edge hold on output one, retriggered once
      want[0] <= 1'b0;
      wr_reg(9'h000, 32'h0);
      wr_reg(9'h080, 32'h0);
      clks(24);
      wr_reg(9'h100, 32'h00a);
      want[0] <= 1'b1;
      clks(24);
      rd_chk(9'h120, 32'h1, 32'h1);
      want[0] <= 1'b0;
      clks(24);
      rd_chk(9'h120, 32'h1, 32'h1);
      clks(40);
      want[0] <= 1'b1;
      clks(24);
      want[0] <= 1'b0;
      clks(84);
      rd_chk(9'h120, 32'h1, 32'h1);
      clks(100);
      rd_chk(9'h120, 32'h0, 32'h1);
      // 5 ms trailing-edge hold: after a rise and a fall of the input the output must still stand, then be off 100 clocks later
      wr_reg(9'h100, 32'h105);
      want[0] <= 1'b1;
      clks(24);
      want[0] <= 1'b0;
      clks(24);
      rd_chk(9'h120, 32'h1, 32'h1);
      clks(100);
      rd_chk(9'h120, 32'h0, 32'h1);
      clks(4);
      give_verdict();
   end
endmodule
